// ==== core/adc_conversion_mode_sequencer.sv ====
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module adc_conversion_mode_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic                             ref_clk,
  input  wire logic                             arst_n,
  input  wire logic [adc_seq_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [adc_seq_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [adc_seq_pkg::DATA_W-1:0]   reg_rdata,
  output logic                                  conv_start,
  output logic                                  conv_abort,
  input  wire logic                             conv_done,
  input  wire logic [adc_seq_pkg::RES_W-1:0]    conv_result,
  output logic      [adc_seq_pkg::CHAN_W-1:0]   mux_select,
  output logic      [7:0]                       ext_input_sel,
  output logic                                  high_ref_sel,
  output logic                                  low_ref_sel,
  output logic                                  ref_mid_sel,
  output logic                                  test_source_sel,
  output logic                                  reserved_sel,
  output logic                                  sequence_complete_flag,
  output logic      [adc_seq_pkg::NUM_SLOTS-1:0] slot_complete_flags,
  output logic      [2:0]                       conversion_mode,
  output logic                                  busy
);

  import adc_seq_pkg::*;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [12:0] chan_decode(input logic [CHAN_W-1:0] ch);
    logic [7:0] ext;
    logic       rsv;
    ext = 8'h00;
    rsv = 1'b0;
    if (ch <= CHAN_EXT_LAST) begin
      ext[ch[2:0]] = 1'b1;
    end else if (ch < CHAN_HIGH_REF) begin
      rsv = 1'b1;
    end
    return {rsv, ch == CHAN_TEST, ch == CHAN_MID_REF, ch == CHAN_LOW_REF,
            ch == CHAN_HIGH_REF, ext};
  endfunction

  function automatic logic [NUM_SLOTS-1:0] slot_onehot(input logic [SLOT_W-1:0] s);
    logic [NUM_SLOTS-1:0] oh;
    oh    = '0;
    oh[s] = 1'b1;
    return oh;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  seq_state_e                state_r;
  seq_state_e                state_nxt;
  logic [CTL0_W-1:0]         ctl0_r;
  logic [CTL1_W-1:0]         ctl1_r;
  logic [CHAN_W-1:0]         chan_r;
  logic [CHAN_W-1:0]         chan_nxt;
  logic [SLOT_W-1:0]         slot_r;
  logic [SLOT_W-1:0]         slot_nxt;
  logic [RES_W-1:0]          result_mem [NUM_SLOTS];
  logic [NUM_SLOTS-1:0]      slot_flags_r;
  logic [NUM_SLOTS-1:0]      slot_flags_nxt;
  logic                      seq_done_r;
  logic                      seq_done_nxt;
  logic [DATA_W-1:0]         rdata_r;
  logic                      start_r;
  logic                      abort_r;
  logic                      busy_r;
  logic [12:0]               decode_r;

  // ------------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------------
  wire                 wr_ctl0   = reg_wr && (reg_addr == FIRST_CTL_IDX);
  wire                 wr_ctl1   = reg_wr && (reg_addr == SECOND_CTL_IDX);
  wire                 ctl_wr    = wr_ctl0 || wr_ctl1;
  wire                 running   = (state_r != ST_IDLE);
  wire                 hit_res   = (reg_addr[4:3] == RESULT_BANK);
  wire [CHAN_W-1:0]    wr_chan   = reg_wdata[CTL1_CHAN_LSB +: CHAN_W];

  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------
  wire                 cont_sel  = ctl1_r[CTL1_CONT_BIT];
  wire                 multi_sel = ctl1_r[CTL1_MULTI_BIT];
  wire                 eight_sel = ctl1_r[CTL1_EIGHT_BIT];
  wire [2:0]           mode_num  = {cont_sel, multi_sel, eight_sel};
  wire [CHAN_W-1:0]    start_ch  = ctl1_r[CTL1_CHAN_LSB +: CHAN_W];
  wire [SLOT_W-1:0]    last_slot = eight_sel ? LONG_LAST : SHORT_LAST;
  wire                 at_last   = (slot_r == last_slot);

  // A result that lands with a control write belongs to the aborted run
  wire                 store     = (state_r == ST_WAIT) && conv_done && !ctl_wr;
  wire                 seq_end   = store && at_last;
  wire                 flag_clr  = wr_ctl1 || (wr_ctl0 && running);

  // ------------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    chan_nxt  = chan_r;
    slot_nxt  = slot_r;
    if (wr_ctl0) begin
      state_nxt = ST_IDLE;
    end else if (wr_ctl1) begin
      state_nxt = ST_ISSUE;
      chan_nxt  = wr_chan;
      slot_nxt  = '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          state_nxt = ST_IDLE;
        end
        ST_ISSUE: begin
          state_nxt = ST_WAIT;
        end
        ST_WAIT: begin
          if (store) begin
            if (at_last) begin
              slot_nxt  = '0;
              chan_nxt  = start_ch;
              state_nxt = cont_sel ? ST_ISSUE : ST_IDLE;
            end else begin
              slot_nxt  = slot_r + 3'h1;
              chan_nxt  = multi_sel ? chan_r + 4'h1 : chan_r;
              state_nxt = ST_ISSUE;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Completion flags
  // ------------------------------------------------------------------
  always_comb begin
    slot_flags_nxt = slot_flags_r;
    seq_done_nxt   = seq_done_r;
    if (flag_clr) begin
      slot_flags_nxt = '0;
      seq_done_nxt   = 1'b0;
    end else begin
      if (store) begin
        slot_flags_nxt = slot_flags_r | slot_onehot(slot_r);
      end
      if (seq_end) begin
        seq_done_nxt = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (reg_addr == FIRST_CTL_IDX) begin
      rd_mux[CTL0_W-1:0] = ctl0_r;
    end else if (reg_addr == SECOND_CTL_IDX) begin
      rd_mux[CTL1_W-1:0] = ctl1_r;
    end else if (reg_addr == STATUS_IDX) begin
      rd_mux[NUM_SLOTS-1:0]             = slot_flags_r;
      rd_mux[STAT_SLOT_LSB +: SLOT_W]   = slot_r;
      rd_mux[STAT_BUSY_BIT]             = running;
      rd_mux[STAT_SEQ_BIT]              = seq_done_r;
    end else if (hit_res) begin
      rd_mux[RES_W-1:0] = result_mem[reg_addr[SLOT_W-1:0]];
    end
  end

  // ------------------------------------------------------------------
  // Flip-flops
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r      <= ST_IDLE;
      ctl0_r       <= FIRST_CTL_RST;
      ctl1_r       <= SECOND_CTL_RST;
      chan_r       <= '0;
      slot_r       <= '0;
      slot_flags_r <= '0;
      seq_done_r   <= 1'b0;
      rdata_r      <= '0;
      start_r      <= 1'b0;
      abort_r      <= 1'b0;
      busy_r       <= 1'b0;
      decode_r     <= 13'h0001;
    end else begin
      state_r      <= state_nxt;
      chan_r       <= chan_nxt;
      slot_r       <= slot_nxt;
      slot_flags_r <= slot_flags_nxt;
      seq_done_r   <= seq_done_nxt;
      rdata_r      <= reg_rd ? rd_mux : '0;
      start_r      <= (state_r == ST_ISSUE) && !ctl_wr;
      abort_r      <= ctl_wr && running;
      busy_r       <= (state_nxt != ST_IDLE);
      decode_r     <= chan_decode(chan_nxt);
      if (wr_ctl0) begin
        ctl0_r <= reg_wdata[CTL0_W-1:0];
      end
      if (wr_ctl1) begin
        ctl1_r <= reg_wdata[CTL1_W-1:0];
      end
    end
  end

  // Result slots hold data only, no reset needed
  always_ff @(posedge ref_clk) begin
    if (store) begin
      result_mem[slot_r] <= conv_result;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign reg_rdata              = rdata_r;
  assign conv_start             = start_r;
  assign conv_abort             = abort_r;
  assign mux_select             = chan_r;
  assign ext_input_sel          = decode_r[7:0];
  assign high_ref_sel           = decode_r[8];
  assign low_ref_sel            = decode_r[9];
  assign ref_mid_sel            = decode_r[10];
  assign test_source_sel        = decode_r[11];
  assign reserved_sel           = decode_r[12];
  assign sequence_complete_flag = seq_done_r;
  assign slot_complete_flags    = slot_flags_r;
  assign conversion_mode        = ctl1_r[CTL1_CONT_BIT -: 3];
  assign busy                   = busy_r;

endmodule

// ==== core/adc_seq_pkg.sv ====
package adc_seq_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int ADDR_W    = 5;
  localparam int DATA_W    = 16;
  localparam int RES_W     = 10;
  localparam int CHAN_W    = 4;
  localparam int SLOT_W    = 3;
  localparam int NUM_SLOTS = 8;
  localparam int CTL0_W    = 8;
  localparam int CTL1_W    = 7;

  // ------------------------------------------------------------------
  // Register offsets (word index on the register port)
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] FIRST_CTL_IDX  = 5'h00;
  localparam logic [ADDR_W-1:0] SECOND_CTL_IDX = 5'h01;
  localparam logic [ADDR_W-1:0] STATUS_IDX     = 5'h02;
  localparam logic [1:0]        RESULT_BANK    = 2'h1;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTL1_CHAN_LSB  = 0;
  localparam int CTL1_EIGHT_BIT = 4;
  localparam int CTL1_MULTI_BIT = 5;
  localparam int CTL1_CONT_BIT  = 6;
  localparam int STAT_SLOT_LSB  = 8;
  localparam int STAT_BUSY_BIT  = 14;
  localparam int STAT_SEQ_BIT   = 15;

  // ------------------------------------------------------------------
  // Reset values and last slot indices
  // ------------------------------------------------------------------
  localparam logic [CTL0_W-1:0] FIRST_CTL_RST  = 8'h00;
  localparam logic [CTL1_W-1:0] SECOND_CTL_RST = 7'h00;
  localparam logic [SLOT_W-1:0] SHORT_LAST     = 3'h3;
  localparam logic [SLOT_W-1:0] LONG_LAST      = 3'h7;

  // ------------------------------------------------------------------
  // Channel codes
  // ------------------------------------------------------------------
  localparam logic [CHAN_W-1:0] CHAN_EXT_LAST = 4'h7;
  localparam logic [CHAN_W-1:0] CHAN_HIGH_REF = 4'hC;
  localparam logic [CHAN_W-1:0] CHAN_LOW_REF  = 4'hD;
  localparam logic [CHAN_W-1:0] CHAN_MID_REF  = 4'hE;
  localparam logic [CHAN_W-1:0] CHAN_TEST     = 4'hF;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} seq_state_e;

endpackage

// ==== verification/adc_seq_properties.sv ====
`timescale 1ns/1ps
module adc_seq_properties (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        conv_done,
  input wire logic        conv_start,
  input wire logic        conv_abort,
  input wire logic        low_ref_sel,
  input wire logic        ref_mid_sel,
  input wire logic        test_source_sel,
  input wire logic [3:0]  mux_select,
  input wire logic [7:0]  ext_input_sel,
  input wire logic        high_ref_sel,
  input wire logic        reserved_sel,
  input wire logic        sequence_complete_flag,
  input wire logic [7:0]  slot_complete_flags,
  input wire logic [2:0]  conversion_mode,
  input wire logic        busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire start_wr = reg_wr && reg_addr == 5'h01;
  wire ctl_wr   = reg_wr && reg_addr <= 5'h01;
  sequence launch_s;
    busy ##1 conv_start;
  endsequence
  a_mode_from_write: assert property (start_wr |=> conversion_mode == $past(reg_wdata[6:4]))
    else $error("mode wrong");
  a_first_channel: assert property (start_wr |=> mux_select == $past(reg_wdata[3:0]))
    else $error("start channel wrong");
  a_start_follows: assert property (start_wr |=> launch_s)
    else $error("no start");
  a_flags_cleared: assert property (start_wr |=> !sequence_complete_flag && slot_complete_flags == 8'h00)
    else $error("flags kept");
  a_flags_hold: assert property (!ctl_wr |=> (slot_complete_flags & $past(slot_complete_flags)) == $past(slot_complete_flags))
    else $error("flag lost");
  a_ext_decode: assert property (!mux_select[3] |-> ext_input_sel == 8'h01 << mux_select[2:0])
    else $error("input decode");
  a_ref_decode: assert property (high_ref_sel == (mux_select == 4'hC) && reserved_sel == (mux_select[3:2] == 2'b10))
    else $error("ref decode");
  a_seq_all_slots: assert property ($rose(sequence_complete_flag) |-> slot_complete_flags == (conversion_mode[0] ? 8'hFF : 8'h0F))
    else $error("early done");
  a_busy_at_done: assert property ($rose(sequence_complete_flag) |-> busy == conversion_mode[2])
    else $error("busy at done");
  a_cont_restart: assert property (conv_done && busy && conversion_mode[2] && !ctl_wr ##1 !ctl_wr |=> conv_start)
    else $error("no restart");
  a_abort_on_write: assert property (ctl_wr |=> conv_abort == $past(busy))
    else $error("abort pulse wrong");
  a_ref_levels: assert property (low_ref_sel == (mux_select == 4'hD) && ref_mid_sel == (mux_select == 4'hE) && test_source_sel == (mux_select == 4'hF))
    else $error("reference decode");
endmodule
bind adc_conversion_mode_sequencer adc_seq_properties u_props (.ref_clk(ref_clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .conv_done(conv_done),
  .conv_start(conv_start), .conv_abort(conv_abort), .low_ref_sel(low_ref_sel),
  .ref_mid_sel(ref_mid_sel), .test_source_sel(test_source_sel),
  .mux_select(mux_select), .ext_input_sel(ext_input_sel),
  .high_ref_sel(high_ref_sel), .reserved_sel(reserved_sel), .busy(busy),
  .sequence_complete_flag(sequence_complete_flag), .slot_complete_flags(slot_complete_flags),
  .conversion_mode(conversion_mode));

// ==== verification/conv_core_model.sv ====
`timescale 1ns/1ps
module conv_core_model (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       conv_start,
  input  wire logic       conv_abort,
  input  wire logic [3:0] mux_select,
  input  wire logic [3:0] lat,
  output logic            conv_done,
  output logic [9:0]      conv_result
);
  logic [3:0] wait_r;
  logic [3:0] chan_r;
  logic [5:0] cnt_r;
  logic       run_r;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_r <= 1'b0;
      conv_done <= 1'b0;
      cnt_r <= 6'h00;
      conv_result <= 10'h3FF;
    end else begin
      conv_done <= 1'b0;
      // Result only valid with done
      conv_result <= ~conv_result;
      if (conv_start) begin
        run_r <= 1'b1;
        wait_r <= lat;
        chan_r <= mux_select;
      end else if (conv_abort) begin
        run_r <= 1'b0;
      end else if (run_r && wait_r == 4'h0) begin
        run_r <= 1'b0;
        conv_done <= 1'b1;
        cnt_r <= cnt_r + 6'h01;
        conv_result <= {cnt_r, chan_r};
      end else begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
  import adc_seq_pkg::*;
  logic        ref_clk, arst_n, reg_wr, reg_rd, conv_start, conv_abort, conv_done;
  logic        busy, sequence_complete_flag;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rdat;
  logic [9:0]  conv_result, s0;
  logic [3:0]  mux_select, lat;
  logic [7:0]  slot_complete_flags;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  adc_conversion_mode_sequencer DUT (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_start(conv_start), .conv_abort(conv_abort), .conv_done(conv_done),
    .conv_result(conv_result), .mux_select(mux_select), .ext_input_sel(), .high_ref_sel(),
    .low_ref_sel(), .ref_mid_sel(), .test_source_sel(), .reserved_sel(),
    .sequence_complete_flag(sequence_complete_flag), .slot_complete_flags(slot_complete_flags),
    .conversion_mode(), .busy(busy));
  conv_core_model core (.ref_clk(ref_clk), .arst_n(arst_n), .conv_start(conv_start),
    .conv_abort(conv_abort), .mux_select(mux_select), .lat(lat), .conv_done(conv_done),
    .conv_result(conv_result));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      $display("unexpected at %0t: run hung", $time);
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic t_regs();
    rd(STATUS_IDX, rdat);
    chk(rdat, 16'h0000);
    wr(FIRST_CTL_IDX, 16'h00A5);
    rd(FIRST_CTL_IDX, rdat);
    chk(rdat, 16'h00A5);
    wr(STATUS_IDX, 16'hFFFF);
    rd(STATUS_IDX, rdat);
    chk(rdat, 16'h0000);
    rd(5'h1F, rdat);
    chk(rdat, 16'h0000);
  endtask
  task automatic t_single(input logic [2:0] m, input logic [3:0] ch);
    logic [3:0] c;
    wr(SECOND_CTL_IDX, {9'h000, m, ch});
    #1;
    for (int i = 0; i < 500 && busy !== 1'b0; i++) @(posedge ref_clk) #1;
    rd(STATUS_IDX, rdat);
    chk({rdat[15:14], rdat[7:0]}, {2'b10, m[0] ? 8'hFF : 8'h0F});
    for (int n = 0; n < (m[0] ? 8 : 4); n++) begin
      rd({RESULT_BANK, 3'(n)}, rdat);
      if (n == 0) s0 = rdat[9:0];
      c = m[1] ? ch + 4'(n) : ch;
      chk(rdat, {6'h00, s0[9:4] + 6'(n), c});
    end
  endtask
  task automatic t_cont(input logic [2:0] m, input logic [3:0] ch, input logic [4:0] stop);
    wr(SECOND_CTL_IDX, {9'h000, m, ch});
    #1;
    for (int i = 0; i < 500 && sequence_complete_flag !== 1'b1; i++) @(posedge ref_clk) #1;
    rd({RESULT_BANK, 3'h0}, rdat);
    s0 = rdat[9:0];
    repeat (9) @(posedge conv_done);
    rd(STATUS_IDX, rdat);
    chk(rdat[15:14], 2'b11);
    rd({RESULT_BANK, 3'h0}, rdat);
    chk({rdat[3:0], 3'h0, rdat[9:4] != s0[9:4]}, {ch, 4'h1});
    wr(stop, 16'h0000);
    #1;
    chk({sequence_complete_flag, slot_complete_flags}, 9'h000);
  endtask
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    lat = 4'h0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_single(3'h0, 4'hC);
    lat <= 4'h6;
    t_single(3'h1, 4'h3);
    t_single(3'h3, 4'h6);
    lat <= 4'h0;
    t_single(3'h2, 4'hE);
    t_cont(3'h4, 4'h5, FIRST_CTL_IDX);
    t_cont(3'h5, 4'hD, SECOND_CTL_IDX);
    t_cont(3'h6, 4'hF, FIRST_CTL_IDX);
    t_cont(3'h7, 4'h2, SECOND_CTL_IDX);
    end_of_test();
  end
endmodule
